// [src/oea_defines.vh]
`ifndef OEA_DEFINES_VH
`define OEA_DEFINES_VH
// =====================================================
// Register byte offsets, and addr[7:5] codes of the setting blocks
`define OEA_A_CTRL 8'h00
`define OEA_A_CMD 8'h04
`define OEA_A_STAT 8'h08
`define OEA_A_COUNT 8'h0C
`define OEA_A_TIME 8'h10
`define OEA_A_ISTAT 8'h14
`define OEA_A_ICLR 8'h18
`define OEA_A_IEN 8'h1C
`define OEA_A_RSEL 8'h20
`define OEA_A_RTIME 8'h24
`define OEA_A_RINFO 8'h28
`define OEA_A_RPTR 8'h2C
`define OEA_A_PHSET 3'h2
`define OEA_A_RESSET 3'h3
// =====================================================
// Control field positions and reset values
`define OEA_C_PHEN 0
`define OEA_C_RESEN 1
`define OEA_C_PP 2
`define OEA_C_SRC 4:3
`define OEA_C_MON 5
`define OEA_C_MOFF 6
`define OEA_C_SG 10:8
`define OEA_CTRL_RST 11'h063
`define OEA_CMD_CLRCNT 0
// Residual source codes
`define OEA_SRC_COARSE 2'h0
`define OEA_SRC_SENS 2'h1
// Interrupt bits
`define OEA_I_ON 0
`define OEA_I_OFF 1
`define OEA_I_REC 2
`define OEA_IRQ_W 3
// Pick-up defaults: phase in 0.01 In, residual in 0.001 In
`define OEA_PH_DEF 16'h0078
`define OEA_RES_DEF 16'h04B0
// Hysteresis: release below 97 of 100
`define OEA_PCT_FULL 8'h64
`define OEA_PCT_RST 8'h61
// Phase step to residual step scale
`define OEA_PH_SCALE 8'h0A
// Setting groups and fault record
`define OEA_NGRP 8
`define OEA_NREC 4'hC
`define OEA_REC_LAST 4'hB
// Ratio fraction bits and divider length
`define OEA_FRAC 8'h00
`define OEA_DIV_STEPS 5'h18
// Time base
`define OEA_MS_NS 32'h000F_4240
`define OEA_CLK_NS 32'h0000_0014
`endif

// [src/oea_alarm.v]
// The strobed register port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`include "oea_defines.vh"
// =====================================================
// Overview of operation
// - Eight setting groups, one selector, changes take effect while running.
// - Three phase magnitudes arrive each 5 ms and are evaluated on arrival.
// - Peak-to-peak mode takes operating values from raw samples.
// - Each phase is compared against the setting independently.
// - Pick-up when any one, two or three phases exceed the setting.
// - One phase setting serves all three phases.
// - Release only below 97 % of the setting.
// - Phase setting in 0.01 In steps, default 1.20 In.
// - Start output only while picked up and not blocked.
// - ON and OFF events with 1 ms time stamps on alarm edges.
// - Cumulative alarm counter, clearable by software.
// - Mask selects ON, OFF or both events for storage.
// - Events carry time stamp and process data at the change.
// - Circular record of twelve operations, written with ON data.
// - Record holds time, event code, phases, peak ratio, group.
// - Residual source chosen from coarse, sensitive or calculated.
// - All residual sources refresh every 5 ms.
// - Residual setting in 0.001 In steps, default 1.20, 97 % release.
module oea_alarm #(
   parameter MS_CYCLES = `OEA_MS_NS / `OEA_CLK_NS
) (
   input wire mclk,
   input wire rstn,
   input wire ce,
   input wire [7:0] addr,
   input wire [31:0] wdata,
   input wire wr,
   input wire rd,
   output reg [31:0] rdata,
   input wire upd,
   input wire [15:0] phase_a_rms,
   input wire [15:0] phase_b_rms,
   input wire [15:0] phase_c_rms,
   input wire [15:0] coarse_residual_rms,
   input wire [15:0] sensitive_residual_rms,
   input wire [15:0] calculated_residual_rms,
   input wire samp_vld,
   input wire [15:0] samp_a,
   input wire [15:0] samp_b,
   input wire [15:0] samp_c,
   input wire [15:0] samp_r,
   input wire blk,
   output reg start,
   output reg ev_vld,
   output reg ev_on,
   output reg [31:0] ev_time,
   output reg [15:0] ev_a,
   output reg [15:0] ev_b,
   output reg [15:0] ev_c,
   output reg [15:0] ev_r,
   output wire irq
);
   localparam S_IDLE = 3'b001;
   localparam S_DIV = 3'b010;
   localparam S_STORE = 3'b100;

   reg [10:0] ctrl;
   reg [15:0] ph_set [0:`OEA_NGRP-1];
   reg [15:0] res_set [0:`OEA_NGRP-1];
   reg [`OEA_IRQ_W-1:0] istat;
   reg [`OEA_IRQ_W-1:0] ien;
   reg [15:0] count;
   reg [31:0] ms_div;
   reg [31:0] ms_cnt;
   reg [3:0] pick;
   reg [63:0] mag_q;
   reg [2:0] state;
   reg [4:0] div_cnt;
   reg [23:0] num;
   reg [15:0] den;
   reg [16:0] rem;
   reg [23:0] quo;
   reg [3:0] r_code;
   reg [2:0] r_sg;
   reg [31:0] r_time;
   reg [31:0] rec_time [0:`OEA_REC_LAST];
   reg [23:0] rec_info [0:`OEA_REC_LAST];
   reg [3:0] rec_wp;
   reg [3:0] rec_n;
   reg [3:0] rec_sel;
   integer k;

   // =====================================================
   // Active settings
   wire [2:0] sg = ctrl[`OEA_C_SG];
   wire pp_mode = ctrl[`OEA_C_PP];
   wire [1:0] src = ctrl[`OEA_C_SRC];
   // Phase setting scaled to 0.001 In, shared by all phases
   wire [23:0] thr_ph_w = ph_set[sg] * `OEA_PH_SCALE;
   wire [15:0] thr_ph = thr_ph_w[15:0];
   wire [15:0] thr_res = res_set[sg];
   wire wr_grp = wr && (addr[7:5] == `OEA_A_PHSET);
   wire wr_rgrp = wr && (addr[7:5] == `OEA_A_RESSET);
   wire en_upd = ce && upd;

   // =====================================================
   // Peak-to-peak trackers, one per channel
   wire [63:0] samp_bus = {samp_r, samp_c, samp_b, samp_a};
   wire [63:0] pp_bus;
   genvar i;
   generate
      for (i = 0; i < 4; i = i + 1) begin : g_pp
         reg signed [15:0] hi;
         reg signed [15:0] lo;
         reg [15:0] pp;
         wire signed [15:0] s = samp_bus[16*i +: 16];
         wire [16:0] diff = {hi[15], hi} - {lo[15], lo};
         assign pp_bus[16*i +: 16] = pp;
         // Window of samples closes on each update
         always @(posedge mclk or negedge rstn) begin
            if (!rstn) begin
               hi <= 16'h8000;
               lo <= 16'h7FFF;
               pp <= 16'h0000;
            end else if (ce) begin
               if (upd) begin
                  pp <= (hi < lo) ? 16'h0000 : diff[15:0];
                  hi <= 16'h8000;
                  lo <= 16'h7FFF;
               end else if (samp_vld) begin
                  if (s > hi)
                     hi <= s;
                  if (s < lo)
                     lo <= s;
               end
            end
         end
      end
   endgenerate

   // =====================================================
   // Operating value selection
   reg [15:0] res_rms;
   always @* begin
      case (src)
         `OEA_SRC_COARSE: res_rms = coarse_residual_rms;
         `OEA_SRC_SENS: res_rms = sensitive_residual_rms;
         default: res_rms = calculated_residual_rms;
      endcase
   end
   wire [63:0] rms_bus = {res_rms, phase_c_rms, phase_b_rms, phase_a_rms};
   wire [63:0] mag_bus = pp_mode ? pp_bus : rms_bus;

   // =====================================================
   // Threshold comparators with built-in 97 % release
   wire [3:0] ch_en = {ctrl[`OEA_C_RESEN], {3{ctrl[`OEA_C_PHEN]}}};
   generate
      for (i = 0; i < 4; i = i + 1) begin : g_cmp
         wire [15:0] m = mag_bus[16*i +: 16];
         wire [15:0] t = (i == 3) ? thr_res : thr_ph;
         wire [23:0] m100 = m * `OEA_PCT_FULL;
         wire [23:0] t97 = t * `OEA_PCT_RST;
         // Evaluated once per arriving update
         always @(posedge mclk or negedge rstn) begin
            if (!rstn)
               pick[i] <= 1'b0;
            else if (ce && !ch_en[i])
               pick[i] <= 1'b0;
            else if (en_upd) begin
               if (m > t)
                  pick[i] <= 1'b1;
               else if (m100 < t97)
                  pick[i] <= 1'b0;
            end
         end
      end
   endgenerate

   wire pick_any = (|pick[2:0]) | pick[3];
   wire next_start = pick_any && !blk;
   wire rise = ce && next_start && !start;
   wire fall = ce && !next_start && start;

   // =====================================================
   // Millisecond time base
   always @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         ms_div <= 32'h0000_0000;
         ms_cnt <= 32'h0000_0000;
      end else if (ce) begin
         if (ms_div == MS_CYCLES - 1) begin
            ms_div <= 32'h0000_0000;
            ms_cnt <= ms_cnt + 32'h0000_0001;
         end else
            ms_div <= ms_div + 32'h0000_0001;
      end
   end

   // =====================================================
   // Alarm output, process data and events
   always @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         start <= 1'b0;
         mag_q <= 64'h0000_0000_0000_0000;
         ev_vld <= 1'b0;
         ev_on <= 1'b0;
         ev_time <= 32'h0000_0000;
         {ev_r, ev_c, ev_b, ev_a} <= 64'h0000_0000_0000_0000;
      end else if (ce) begin
         start <= next_start;
         if (upd)
            mag_q <= mag_bus;
         ev_vld <= (rise && ctrl[`OEA_C_MON]) ||
                   (fall && ctrl[`OEA_C_MOFF]);
         if (rise || fall) begin
            ev_on <= rise;
            ev_time <= ms_cnt;
            {ev_r, ev_c, ev_b, ev_a} <= mag_q;
         end
      end
   end

   // =====================================================
   // Alarm counter, clear and increment together load 1
   wire clr_cnt = wr && (addr == `OEA_A_CMD) && wdata[`OEA_CMD_CLRCNT];
   always @(posedge mclk or negedge rstn) begin
      if (!rstn)
         count <= 16'h0000;
      else if (ce) begin
         if (rise)
            count <= clr_cnt ? 16'h0001 : count + 16'h0001;
         else if (clr_cnt)
            count <= 16'h0000;
      end
   end

   // =====================================================
   // Peak ratio divider and fault record writer
   wire [15:0] mx_ab = (mag_q[15:0] > mag_q[31:16]) ?
                       mag_q[15:0] : mag_q[31:16];
   wire [15:0] mx_ph = (mx_ab > mag_q[47:32]) ? mx_ab : mag_q[47:32];
   wire use_ph = |pick[2:0];
   wire [16:0] rem_sh = {rem[15:0], num[23]};
   wire rec_wr = ce && (state == S_STORE);
   always @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         state <= S_IDLE;
         div_cnt <= 5'h00;
         num <= 24'h00_0000;
         den <= 16'h0000;
         rem <= 17'h0_0000;
         quo <= 24'h00_0000;
         r_code <= 4'h0;
         r_sg <= 3'h0;
         r_time <= 32'h0000_0000;
         rec_wp <= 4'h0;
         rec_n <= 4'h0;
      end else if (ce) begin
         case (state)
            S_IDLE: begin
               if (rise) begin
                  num <= {use_ph ? mx_ph : mag_q[63:48], `OEA_FRAC};
                  den <= use_ph ? thr_ph : thr_res;
                  rem <= 17'h0_0000;
                  quo <= 24'h00_0000;
                  div_cnt <= `OEA_DIV_STEPS;
                  r_code <= {pick[2:0], pick[3]};
                  r_sg <= sg;
                  r_time <= ms_cnt;
                  state <= S_DIV;
               end
            end
            S_DIV: begin
               num <= {num[22:0], 1'b0};
               if (rem_sh >= {1'b0, den}) begin
                  rem <= rem_sh - {1'b0, den};
                  quo <= {quo[22:0], 1'b1};
               end else begin
                  rem <= rem_sh;
                  quo <= {quo[22:0], 1'b0};
               end
               div_cnt <= div_cnt - 5'h01;
               if (div_cnt == 5'h01)
                  state <= S_STORE;
            end
            S_STORE: begin
               rec_wp <= (rec_wp == `OEA_REC_LAST) ? 4'h0 :
                         rec_wp + 4'h1;
               if (rec_n != `OEA_NREC)
                  rec_n <= rec_n + 4'h1;
               state <= S_IDLE;
            end
            default: state <= S_IDLE;
         endcase
      end
   end

   // Ratio in 8.8 format, saturated
   wire [15:0] ratio = (den == 16'h0000 || |quo[23:16]) ?
                       16'hFFFF : quo[15:0];
   always @(posedge mclk) begin
      if (rec_wr) begin
         rec_time[rec_wp] <= r_time;
         rec_info[rec_wp] <= {1'b1, r_sg, r_code, ratio};
      end
   end

   // =====================================================
   // Register writes and interrupt status
   wire [`OEA_IRQ_W-1:0] ev_set = {rec_wr, fall, rise};
   wire [`OEA_IRQ_W-1:0] iclr = (wr && addr == `OEA_A_ICLR) ?
                               wdata[`OEA_IRQ_W-1:0] : 3'h0;
   always @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         ctrl <= `OEA_CTRL_RST;
         istat <= 3'h0;
         ien <= 3'h0;
         rec_sel <= 4'h0;
         for (k = 0; k < `OEA_NGRP; k = k + 1) begin
            ph_set[k] <= `OEA_PH_DEF;
            res_set[k] <= `OEA_RES_DEF;
         end
      end else if (ce) begin
         istat <= (istat & ~iclr) | ev_set;
         if (wr && addr == `OEA_A_CTRL)
            ctrl <= wdata[10:0];
         if (wr && addr == `OEA_A_IEN)
            ien <= wdata[`OEA_IRQ_W-1:0];
         if (wr && addr == `OEA_A_RSEL)
            rec_sel <= wdata[3:0];
         if (wr_grp)
            ph_set[addr[4:2]] <= wdata[15:0];
         if (wr_rgrp)
            res_set[addr[4:2]] <= wdata[15:0];
      end
   end
   assign irq = |(istat & ien);

   // =====================================================
   // Register reads, data valid one cycle after the strobe
   wire [3:0] rs = (rec_sel > `OEA_REC_LAST) ? 4'h0 : rec_sel;
   reg [31:0] rd_mux;
   always @* begin
      rd_mux = 32'h0000_0000;
      if (addr[7:5] == `OEA_A_PHSET)
         rd_mux = {16'h0000, ph_set[addr[4:2]]};
      else if (addr[7:5] == `OEA_A_RESSET)
         rd_mux = {16'h0000, res_set[addr[4:2]]};
      else begin
         case (addr)
            `OEA_A_CTRL: rd_mux = {21'h00_0000, ctrl};
            `OEA_A_STAT: rd_mux = {25'h000_0000, blk, pick, start};
            `OEA_A_COUNT: rd_mux = {16'h0000, count};
            `OEA_A_TIME: rd_mux = ms_cnt;
            `OEA_A_ISTAT: rd_mux = {29'h0000_0000, istat};
            `OEA_A_IEN: rd_mux = {29'h0000_0000, ien};
            `OEA_A_RSEL: rd_mux = {28'h000_0000, rec_sel};
            `OEA_A_RTIME: rd_mux = rec_time[rs];
            `OEA_A_RINFO: rd_mux = {8'h00, rec_info[rs]};
            `OEA_A_RPTR: rd_mux = {24'h00_0000, rec_n, rec_wp};
            default: rd_mux = 32'h0000_0000;
         endcase
      end
   end
   always @(posedge mclk or negedge rstn) begin
      if (!rstn)
         rdata <= 32'h0000_0000;
      else if (ce)
         rdata <= rd ? rd_mux : 32'h0000_0000;
   end
endmodule // oea_alarm

// [tb/oea_meas_src.sv]
`timescale 1ns/1ps
// =====================================================
// Front end model: update strobe, magnitudes and raw samples
module oea_meas_src #(
   parameter PER = 40
) (
   input wire mclk,
   input wire rstn,
   input wire [95:0] mags,
   output reg upd,
   output wire [95:0] rms,
   output reg samp_vld,
   output wire [15:0] samp
);
   reg [7:0] cnt;
   reg [95:0] hold;
   reg pos;
   // One magnitude set per period on a fixed time base
   always @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         cnt <= 8'h00;
         upd <= 1'b0;
         hold <= 96'h0;
      end else begin
         cnt <= (cnt == PER - 1) ? 8'h00 : cnt + 8'h01;
         upd <= (cnt == PER - 1);
         if (cnt == PER - 1) begin
            hold <= mags;
         end
      end
   end
   // Raw samples alternate sign on every valid strobe
   always @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         samp_vld <= 1'b0;
         pos <= 1'b0;
      end else begin
         samp_vld <= ~samp_vld;
         pos <= pos ^ samp_vld;
      end
   end
   // Stale values are shown inverted so nothing rests on them
   assign rms = upd ? hold : ~hold;
   assign samp = samp_vld ? {16{pos}} : {cnt, cnt};
endmodule // oea_meas_src

// [tb/oea_alarm_props.sv]
`timescale 1ns/1ps
// =====================================================
// Port-level properties of the alarm block
module oea_alarm_props (
   input wire mclk,
   input wire rstn,
   input wire ce,
   input wire rd,
   input wire [31:0] rdata,
   input wire upd,
   input wire [15:0] phase_a_rms,
   input wire blk,
   input wire start,
   input wire ev_vld,
   input wire ev_on,
   input wire [15:0] ev_a
);
   reg [15:0] last_a;
   // Phase A magnitude of the latest accepted update
   always @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         last_a <= 16'h0000;
      end else if (ce && upd) begin
         last_a <= phase_a_rms;
      end
   end
   default clocking dc @(posedge mclk);
   endclocking
   default disable iff (!rstn);
   chk_blk_stops_start: assert property (ce && blk |=> !start)
      else $error("start high after block");
   chk_on_at_rise: assert property (ev_vld && ev_on |-> $rose(start))
      else $error("on event without start rise");
   chk_off_at_fall: assert property (ev_vld && !ev_on |-> $fell(start))
      else $error("off event without start fall");
   chk_event_pulse: assert property (ev_vld && ce |=>
      !ev_vld || ev_on != $past(ev_on))
      else $error("event strobe held");
   chk_event_data: assert property (ev_vld |-> ev_a == last_a)
      else $error("event data not from last update");
   chk_rise_cause: assert property ($rose(start) |->
      $past(upd, 2) || $past(blk, 2))
      else $error("start rose without update or unblock");
   chk_fall_cause: assert property ($fell(start) |->
      $past(upd, 2) || $past(blk))
      else $error("start fell without update or block");
   chk_rdata_idle: assert property (!rd && ce |=> rdata == 32'h0000_0000)
      else $error("read data outside read slot");
   chk_freeze_hold: assert property (!ce |=> $stable(start) && $stable(ev_vld))
      else $error("state moved while disabled");
   cover property ($rose(start));
   cover property (ev_vld && !ev_on);
   cover property (!ce && start);
endmodule // oea_alarm_props
bind oea_alarm oea_alarm_props chk_u (
   .mclk(mclk), .rstn(rstn), .ce(ce), .rd(rd), .rdata(rdata), .upd(upd),
   .phase_a_rms(phase_a_rms), .blk(blk), .start(start), .ev_vld(ev_vld),
   .ev_on(ev_on), .ev_a(ev_a));

// [tb/overcurrent_earthfault_alarm_bench.sv]
`timescale 1ns/1ps
// =====================================================
// Self-checking bench for the alarm block
module overcurrent_earthfault_alarm_bench;
   localparam PER = 40;
   reg mclk = 1'b0;
   reg rstn = 1'b0;
   reg ce = 1'b1;
   reg wr = 1'b0;
   reg rd = 1'b0;
   reg blk = 1'b0;
   reg pend = 1'b0;
   reg [7:0] addr = 8'h00;
   reg [31:0] wdata = 32'h0000_0000;
   reg [95:0] mags = 96'h0;
   reg [95:0] mv;
   reg [1:0] msk = 2'h3;
   reg [15:0] lo, v;
   reg [63:0] q;
   reg [16:0] e;
   reg [63:0] exp_rd[$];
   reg [16:0] exp_ev[$];
   wire [95:0] rms;
   wire [15:0] samp, ev_a;
   wire [31:0] rdata;
   wire upd, samp_vld, start, ev_vld, ev_on, irq;
   integer fails = 0, n_checks = 0, n_rise = 0, n_cnt = 0, i, k;
   // Clock, 20 ns period
   always #10 mclk = ~mclk;
   oea_meas_src #(.PER(PER)) src_u (
      .mclk(mclk), .rstn(rstn), .mags(mags), .upd(upd), .rms(rms),
      .samp_vld(samp_vld), .samp(samp));
   oea_alarm #(.MS_CYCLES(10)) dut_u (
      .mclk(mclk), .rstn(rstn), .ce(ce), .addr(addr), .wdata(wdata),
      .wr(wr), .rd(rd), .rdata(rdata), .upd(upd),
      .phase_a_rms(rms[95:80]), .phase_b_rms(rms[79:64]),
      .phase_c_rms(rms[63:48]), .coarse_residual_rms(rms[47:32]),
      .sensitive_residual_rms(rms[31:16]),
      .calculated_residual_rms(rms[15:0]), .samp_vld(samp_vld),
      .samp_a(samp), .samp_b(samp), .samp_c(samp), .samp_r(samp),
      .blk(blk), .start(start), .ev_vld(ev_vld), .ev_on(ev_on),
      .ev_time(), .ev_a(ev_a), .ev_b(), .ev_c(), .ev_r(), .irq(irq));
   // =====================================================
   // Shared tasks
   task chk(input string n, input [31:0] x, input [31:0] g);
      begin
         n_checks = n_checks + 1;
         if (g !== x) begin
            fails = fails + 1;
            $display("unexpected %s exp %h got %h", n, x, g);
         end
      end
   endtask
   task wreg(input [7:0] a, input [31:0] d);
      begin
         @(posedge mclk);
         wr <= 1'b1;
         addr <= a;
         wdata <= d;
         @(posedge mclk);
         wr <= 1'b0;
      end
   endtask
   task rregm(input [7:0] a, input [31:0] x, input [31:0] m);
      begin
         @(posedge mclk);
         rd <= 1'b1;
         addr <= a;
         exp_rd.push_back({m, x});
         @(posedge mclk);
         rd <= 1'b0;
      end
   endtask
   task rreg(input [7:0] a, input [31:0] x);
      rregm(a, x, 32'hFFFF_FFFF);
   endtask
   task ev(input on, input [15:0] a);
      begin
         if (on) begin
            n_rise = n_rise + 1;
            n_cnt = n_cnt + 1;
         end
         if (msk[!on]) exp_ev.push_back({on, a});
      end
   endtask
   task setm(input [95:0] m);
      begin
         mags <= m;
         repeat (2) begin
            k = 0;
            @(posedge mclk);
            while (!upd && k < 100) begin
               k = k + 1;
               @(posedge mclk);
            end
         end
         repeat (4) @(posedge mclk);
      end
   endtask
   function [95:0] ph(input integer p, input [15:0] x, input [15:0] y);
      begin
         ph = {y, y, y, 48'h0};
         ph[95 - 16 * p -: 16] = x;
      end
   endfunction
   task end_of_test;
      begin
         $display("checks %0d mismatches %0d", n_checks, fails);
         if (fails == 0 && n_checks > 0) begin
            $display("STATUS OK");
         end else begin
            $display("STATUS NOT OK");
         end
         $finish;
      end
   endtask
   // Monitor: takes the oldest note as each result appears
   always @(negedge mclk) begin
      if (pend) begin
         q = exp_rd.pop_front();
         chk("rdata", q[31:0], rdata & q[63:32]);
      end
      pend = rd;
      if (ev_vld) begin
         e = (exp_ev.size() > 0) ? exp_ev.pop_front() : 17'h1_FFFF;
         chk("event", {15'h0, e}, {15'h0, ev_on, ev_a});
      end
   end
   // Watchdog, several times the expected run
   initial begin
      #(20 * 30000);
      fails = fails + 1;
      end_of_test;
   end
   // =====================================================
   // Main sequence
   initial begin
      void'($urandom(69937));
      repeat (3) @(posedge mclk);
      rstn <= 1'b1;
      rreg(8'h00, 32'h0000_0063);
      rreg(8'h40, 32'h0000_0078);
      rreg(8'h7C, 32'h0000_04B0);
      wreg(8'h0C, 32'h0000_1234);
      rreg(8'h0C, 32'h0000_0000);
      rreg(8'h3C, 32'h0000_0000);
      $display("test reset done");
      for (i = 0; i < 3; i = i + 1) begin
         lo = $urandom % 1000;
         setm(ph(i, 16'h04B0, lo));
         ev(1, i ? lo : 16'h04B1);
         setm(ph(i, 16'h04B1, lo));
         rreg(8'h08, 32'h1 | (32'h2 << i));
         setm(ph(i, 16'h048C, lo));
         ev(0, i ? lo : 16'h048B);
         setm(ph(i, 16'h048B, lo));
      end
      $display("test phases done");
      ev(1, 16'h05DC);
      setm({48'h05DC_05DC_05DC, 48'h0});
      rreg(8'h08, 32'h0000_000F);
      ev(0, 16'h05DC);
      blk <= 1'b1;
      repeat (4) @(posedge mclk);
      rreg(8'h08, 32'h0000_002E);
      ev(1, 16'h05DC);
      repeat (40) @(posedge mclk);
      blk <= 1'b0;
      repeat (4) @(posedge mclk);
      ev(0, 16'h0000);
      setm(96'h0);
      rreg(8'h0C, {16'h0, 16'(n_cnt)});
      wreg(8'h04, 32'h0000_0001);
      n_cnt = 0;
      rreg(8'h0C, 32'h0000_0000);
      $display("test block and counter done");
      for (i = 0; i < 4; i = i + 1) begin
         msk = i[1:0];
         wreg(8'h00, 32'h0000_0003 | (i << 5));
         ev(1, 16'h0514);
         setm({16'h0514, 80'h0});
         ev(0, 16'h0000);
         setm(96'h0);
      end
      msk = 2'h3;
      $display("test masks done");
      for (i = 0; i < 3; i = i + 1) begin
         wreg(8'h00, 32'h0000_0063 | (i << 3));
         mv = 96'h04B1 << (32 - 16 * i);
         setm(mv ^ {48'h0, 48'h04B1_04B1_04B1});
         ev(1, 16'h0000);
         setm(mv);
         rreg(8'h08, 32'h0000_0011);
         ev(0, 16'h0000);
         setm(96'h0);
      end
      $display("test residual done");
      for (i = 0; i < 8; i = i + 1) begin
         v = 16'h0064 + $urandom % 100;
         wreg(8'h40 + 8'(4 * i), {16'h0, v});
         wreg(8'h00, 32'h0000_0063 | (i << 8));
         setm({v * 16'h000A, 80'h0});
         ev(1, v * 16'h000A + 16'h0001);
         setm({v * 16'h000A + 16'h0001, 80'h0});
         ev(0, 16'h0000);
         setm(96'h0);
      end
      wreg(8'h20, 32'((n_rise - 1) % 12));
      rregm(8'h28, 32'h00F2_0000, 32'hFFFF_0000);
      rreg(8'h2C, {24'h0, 4'hC, 4'(n_rise % 12)});
      $display("test groups and records done");
      // Zero setting: only raw-sample swings of 1 can pick phases B and C
      wreg(8'h40, 32'h0000_0000);
      wreg(8'h00, 32'h0000_0067);
      ev(1, 16'h0001);
      setm({16'h0001, 80'h0});
      rreg(8'h08, 32'h0000_000F);
      ev(0, 16'h0001);
      wreg(8'h40, 32'h0000_0078);
      setm({16'h0001, 80'h0});
      $display("test peak mode done");
      wreg(8'h00, 32'h0000_0063);
      wreg(8'h18, 32'h0000_0007);
      wreg(8'h1C, 32'h0000_0001);
      rreg(8'h14, 32'h0000_0000);
      ev(1, 16'h0800);
      setm({16'h0800, 80'h0});
      rreg(8'h14, 32'h0000_0005);
      @(negedge mclk);
      chk("irq", 32'h1, {31'h0, irq});
      @(posedge mclk);
      ce <= 1'b0;
      repeat (5) @(posedge mclk);
      ce <= 1'b1;
      wreg(8'h18, 32'h0000_0001);
      @(negedge mclk);
      chk("irq", 32'h0, {31'h0, irq});
      @(posedge mclk);
      ev(0, 16'h0000);
      setm(96'h0);
      rreg(8'h14, 32'h0000_0006);
      @(negedge mclk);
      chk("irq", 32'h0, {31'h0, irq});
      rreg(8'h0C, {16'h0, 16'(n_cnt)});
      $display("test interrupt done");
      repeat (2) @(posedge mclk);
      chk("pending", 32'h0, exp_ev.size());
      end_of_test;
   end
endmodule // overcurrent_earthfault_alarm_bench
